/* File: rtl/osp_pkg.sv */
/*
  Shared constants of the octal flash read-capture block: register
  offsets, field positions, timing counts and the sequencer states.
  Assumes nothing of its surroundings.
*/
package osp_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_DELAY = 8'h04;
  localparam logic [7:0] A_CMD   = 8'h08;
  localparam logic [7:0] A_ADDR  = 8'h0C;
  localparam logic [7:0] A_TX    = 8'h10;
  localparam logic [7:0] A_RX    = 8'h14;
  localparam logic [7:0] A_STAT  = 8'h18;

  // Control bits
  localparam int C_PHY    = 0;
  localparam int C_STAGED = 1;
  localparam int C_HWPOLL = 2;

  // Command fields
  localparam int CMD_LEN_LSB = 8;
  localparam int CMD_WR      = 12;

  // Status bits
  localparam int ST_BUSY     = 0;
  localparam int ST_POLLING  = 1;
  localparam int ST_NOPOLL   = 2;
  localparam int ST_MISS     = 3;
  localparam int ST_DONE     = 4;
  localparam int ST_CONFLICT = 5;

  localparam int         DELAY_W      = 4;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  localparam int         DUMMY_SLOTS  = 8;
  localparam logic [7:0] WIN_SLACK    = 8'h08;
  localparam logic [7:0] POLL_OPC     = 8'h05;
  localparam int         FL_BUSY_BIT  = 0;
  localparam logic [3:0] END_CYC      = 4'h2;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_OPC  = 7'h02,
    S_ADR  = 7'h04,
    S_DUM  = 7'h08,
    S_DAT  = 7'h10,
    S_TAIL = 7'h20,
    S_END  = 7'h40
  } osp_state_t;

endpackage

/* File: rtl/osp_sync.sv */
/*
  Two-flop level synchroniser into the destination clock.
  Assumes the source level is stable for more than two destination edges.
*/
`timescale 1ns/10ps
module osp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: rtl/osp_dqs_cap.sv */
/*
  Strobe-domain capture: each rising edge of the flash data strobe takes
  one byte into one of two alternating slots and flips a toggle.
  Assumes the system side reads a slot only after seeing its toggle.
*/
`timescale 1ns/10ps
module osp_dqs_cap (
  input  wire logic       dqs_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] dq,
  output logic      [7:0] slot0,
  output logic      [7:0] slot1,
  output logic            tog
);

  always_ff @(posedge dqs_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slot0 <= 8'h00;
      slot1 <= 8'h00;
      tog   <= 1'b0;
    end
    else
    begin
      // Slot chosen by toggle so the other one stays stable while read
      if (tog)
        slot1 <= dq;
      else
        slot0 <= dq;
      tog <= ~tog;
    end
  end

endmodule

/* File: rtl/osp_phy_read_top.sv */
/*
  Octal flash access sequencer with strobe-based read capture, an
  internal-clock capture window shifted by a read-delay setting, optional
  staged capture, and hardware busy polling after writes except in PHY mode with a nonzero read delay.
  Assumes an APB master on sys_clk and a flash that returns a strobe.
*/
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
module osp_phy_read_top #(
  parameter int DUMMY = osp_pkg::DUMMY_SLOTS
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fl_dqs,
  input  wire logic [7:0]  fl_dq_i,
  output logic      [7:0]  fl_dq_o,
  output logic             fl_dq_oe,
  output logic             fl_sclk,
  output logic             fl_cs_n
);

  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0]  i);
    byte_of = w[{i, 3'b000} +: 8];
  endfunction

  osp_pkg::osp_state_t state_q;
  logic [2:0]  ctrl_q;
  logic [3:0]  delay_q;
  logic [23:0] addr_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic        miss_q;
  logic        done_q;
  logic        conf_q;
  logic        pready_q;
  logic        half_q;
  logic [3:0]  cnt_q;
  logic [7:0]  opc_q;
  logic [1:0]  len_q;
  logic        wr_q;
  logic        polling_q;
  logic        act_phy_q;
  logic        act_staged_q;
  logic        act_hwpoll_q;
  logic        act_work_q;
  logic [3:0]  act_delay_q;
  logic [7:0]  win_cnt_q;
  logic [2:0]  got_q;
  logic [1:0]  put_q;
  logic [1:0]  spt_q;
  logic        st_v_q;
  logic [7:0]  st_b_q;
  logic        tog_seen_q;
  logic [7:0]  slot0;
  logic [7:0]  slot1;
  logic        tog_raw;
  logic        tog_s;
  logic [7:0]  dq_s;

  wire apb_acc = psel & penable;
  wire wr_fin  = apb_acc & pready_q & pwrite;
  wire idle    = (state_q == osp_pkg::S_IDLE);
  wire start   = wr_fin & (paddr == osp_pkg::A_CMD) & idle;
  wire clr_hit = wr_fin & (paddr == osp_pkg::A_STAT);
  wire work_live = ctrl_q[osp_pkg::C_PHY] & (delay_q != 4'h0);

  osp_dqs_cap u_cap (
    .dqs_clk (fl_dqs),
    .resetn  (resetn),
    .dq      (fl_dq_i),
    .slot0   (slot0),
    .slot1   (slot1),
    .tog     (tog_raw)
  );

  osp_sync #(.W(1)) u_tog_sync (
    .clk    (sys_clk),
    .resetn (resetn),
    .d      (tog_raw),
    .q      (tog_s)
  );

  osp_sync #(.W(8)) u_dq_sync (
    .clk    (sys_clk),
    .resetn (resetn),
    .d      (fl_dq_i),
    .q      (dq_s)
  );

  // Capture path
  wire       in_rx    = ~wr_q & ((state_q == osp_pkg::S_DAT) |
                                 (state_q == osp_pkg::S_TAIL));
  wire       rx_edge  = tog_s ^ tog_seen_q;
  wire [7:0] slot_b   = tog_seen_q ? slot1 : slot0;
  wire       win_open = win_cnt_q >= {4'h0, act_delay_q};
  wire       room     = got_q <= {1'b0, len_q};
  wire       phy_v    = act_phy_q & in_rx & rx_edge & win_open;
  wire       np_v     = ~act_phy_q & spt_q[1];
  wire       acc_v    = (phy_v | np_v) & room;
  wire [7:0] acc_b    = act_phy_q ? slot_b : dq_s;
  wire       store_v  = act_staged_q ? st_v_q : acc_v;
  wire [7:0] store_b  = act_staged_q ? st_b_q : acc_b;
  wire       early    = act_phy_q & in_rx & rx_edge & ~win_open;
  wire [7:0] win_end  = {5'h00, len_q, 1'b0} + 8'h02 +
                        {4'h0, act_delay_q} + osp_pkg::WIN_SLACK;
  wire       tail_end = (state_q == osp_pkg::S_TAIL) & (win_cnt_q >= win_end);
  wire       short_rd = tail_end & (got_q != ({1'b0, len_q} + 3'h1));
  wire       end_last = (state_q == osp_pkg::S_END) &
                        (cnt_q == osp_pkg::END_CYC - 4'h1);
  wire       fl_busy  = rx_q[osp_pkg::FL_BUSY_BIT];
  wire       repoll   = (wr_q & act_hwpoll_q & ~act_work_q) |
                        (polling_q & fl_busy);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_q <= 1'b0;
      pready   <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end
    else
    begin
      pready_q <= apb_acc & ~pready_q;
      pready   <= apb_acc & ~pready_q;
      if (apb_acc & ~pready_q)
      begin
        pslverr <= 1'b0;
        if (paddr == osp_pkg::A_CTRL)
          prdata <= {29'h0000_0000, ctrl_q};
        else if (paddr == osp_pkg::A_DELAY)
          prdata <= {28'h000_0000, delay_q};
        else if (paddr == osp_pkg::A_CMD)
        begin
          prdata  <= {19'h0_0000, wr_q, 2'h0, len_q, opc_q};
          pslverr <= pwrite & ~idle;
        end
        else if (paddr == osp_pkg::A_ADDR)
          prdata <= {8'h00, addr_q};
        else if (paddr == osp_pkg::A_TX)
          prdata <= tx_q;
        else if (paddr == osp_pkg::A_RX)
          prdata <= rx_q;
        else if (paddr == osp_pkg::A_STAT)
          prdata <= {26'h000_0000, conf_q, done_q, miss_q, work_live,
                     polling_q, ~idle};
        else
        begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q  <= osp_pkg::CTRL_RST;
      delay_q <= 4'h0;
      addr_q  <= 24'h00_0000;
      tx_q    <= 32'h0000_0000;
    end
    else if (wr_fin)
    begin
      if (paddr == osp_pkg::A_CTRL)
        ctrl_q <= pwdata[2:0];
      else if (paddr == osp_pkg::A_DELAY)
        delay_q <= pwdata[3:0];
      else if (paddr == osp_pkg::A_ADDR)
        addr_q <= pwdata[23:0];
      else if (paddr == osp_pkg::A_TX)
        tx_q <= pwdata;
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      miss_q <= 1'b0;
      done_q <= 1'b0;
      conf_q <= 1'b0;
    end
    else
    begin
      miss_q <= early | short_rd |
                (miss_q & ~(clr_hit & pwdata[osp_pkg::ST_MISS]));
      done_q <= (end_last & ~repoll) |
                (done_q & ~(clr_hit & pwdata[osp_pkg::ST_DONE]));
      conf_q <= (start & pwdata[osp_pkg::CMD_WR] &
                 ctrl_q[osp_pkg::C_STAGED]) |
                (conf_q & ~(clr_hit & pwdata[osp_pkg::ST_CONFLICT]));
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q      <= osp_pkg::S_IDLE;
      half_q       <= 1'b0;
      cnt_q        <= 4'h0;
      opc_q        <= 8'h00;
      len_q        <= 2'h0;
      wr_q         <= 1'b0;
      polling_q    <= 1'b0;
      act_phy_q    <= 1'b0;
      act_staged_q <= 1'b0;
      act_hwpoll_q <= 1'b0;
      act_work_q   <= 1'b0;
      act_delay_q  <= 4'h0;
    end
    else
    begin
      case (state_q)
        osp_pkg::S_IDLE:
          if (start)
          begin
            // Settings frozen for the whole access
            act_phy_q    <= ctrl_q[osp_pkg::C_PHY];
            act_staged_q <= ctrl_q[osp_pkg::C_STAGED];
            act_hwpoll_q <= ctrl_q[osp_pkg::C_HWPOLL];
            act_work_q   <= work_live;
            act_delay_q  <= delay_q;
            opc_q        <= pwdata[7:0];
            len_q        <= pwdata[osp_pkg::CMD_LEN_LSB +: 2];
            wr_q         <= pwdata[osp_pkg::CMD_WR];
            polling_q    <= 1'b0;
            half_q       <= 1'b0;
            cnt_q        <= 4'h0;
            state_q      <= osp_pkg::S_OPC;
          end
        osp_pkg::S_OPC:
        begin
          half_q <= ~half_q;
          if (half_q)
            state_q <= polling_q ? osp_pkg::S_DAT : osp_pkg::S_ADR;
        end
        osp_pkg::S_ADR:
        begin
          half_q <= ~half_q;
          if (half_q)
          begin
            cnt_q <= (cnt_q == 4'h2) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'h2)
              state_q <= wr_q ? osp_pkg::S_DAT : osp_pkg::S_DUM;
          end
        end
        osp_pkg::S_DUM:
        begin
          half_q <= ~half_q;
          if (half_q)
          begin
            cnt_q <= (cnt_q == 4'(DUMMY - 1)) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'(DUMMY - 1))
              state_q <= osp_pkg::S_DAT;
          end
        end
        osp_pkg::S_DAT:
        begin
          half_q <= ~half_q;
          if (half_q)
          begin
            cnt_q <= (cnt_q == {2'h0, len_q}) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == {2'h0, len_q})
              state_q <= wr_q ? osp_pkg::S_END : osp_pkg::S_TAIL;
          end
        end
        osp_pkg::S_TAIL:
          if (tail_end)
            state_q <= osp_pkg::S_END;
        osp_pkg::S_END:
        begin
          cnt_q <= end_last ? 4'h0 : cnt_q + 4'h1;
          if (end_last)
          begin
            if (repoll)
            begin
              polling_q <= 1'b1;
              wr_q      <= 1'b0;
              len_q     <= 2'h0;
              opc_q     <= osp_pkg::POLL_OPC;
              state_q   <= osp_pkg::S_OPC;
            end
            else
            begin
              polling_q <= 1'b0;
              state_q   <= osp_pkg::S_IDLE;
            end
          end
        end
        default:
          state_q <= osp_pkg::S_IDLE;
      endcase
    end
  end

  // Window timer, capture bookkeeping and optional staging register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      win_cnt_q  <= 8'h00;
      got_q      <= 3'h0;
      put_q      <= 2'h0;
      spt_q      <= 2'h0;
      st_v_q     <= 1'b0;
      st_b_q     <= 8'h00;
      tog_seen_q <= 1'b0;
      rx_q       <= 32'h0000_0000;
    end
    else
    begin
      tog_seen_q <= tog_s;
      spt_q <= {spt_q[0], (state_q == osp_pkg::S_DAT) & half_q & ~wr_q};
      if (in_rx)
        win_cnt_q <= (win_cnt_q == 8'hFF) ? win_cnt_q : win_cnt_q + 8'h01;
      else
        win_cnt_q <= 8'h00;
      st_v_q <= acc_v & act_staged_q;
      st_b_q <= acc_b;
      if (state_q == osp_pkg::S_OPC && !half_q)
      begin
        got_q <= 3'h0;
        put_q <= 2'h0;
        rx_q  <= 32'h0000_0000;
      end
      else
      begin
        if (acc_v)
          got_q <= got_q + 3'h1;
        if (store_v)
        begin
          rx_q[{put_q, 3'b000} +: 8] <= store_b;
          put_q <= put_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fl_cs_n  <= 1'b1;
      fl_sclk  <= 1'b0;
      fl_dq_o  <= 8'h00;
      fl_dq_oe <= 1'b0;
    end
    else
    begin
      fl_cs_n  <= idle | (state_q == osp_pkg::S_END);
      fl_sclk  <= half_q & ~idle & (state_q != osp_pkg::S_END) &
                  (state_q != osp_pkg::S_TAIL);
      fl_dq_oe <= (state_q == osp_pkg::S_OPC) |
                  (state_q == osp_pkg::S_ADR) |
                  ((state_q == osp_pkg::S_DAT) & wr_q);
      if (state_q == osp_pkg::S_OPC)
        fl_dq_o <= opc_q;
      else if (state_q == osp_pkg::S_ADR)
        fl_dq_o <= byte_of({8'h00, addr_q}, 2'(2'h2 - cnt_q[1:0]));
      else if (state_q == osp_pkg::S_DAT)
        fl_dq_o <= byte_of(tx_q, cnt_q[1:0]);
      else
        fl_dq_o <= 8'h00;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  apb_wait_a: assert property (apb_acc && !pready_q |=> pready)
    else $error("apb answer not one cycle after access");
  strobe_src_a: assert property (acc_v && act_phy_q |-> rx_edge)
    else $error("phy byte taken without strobe event");
  win_open_a: assert property (acc_v && act_phy_q |->
                               win_cnt_q >= {4'h0, act_delay_q})
    else $error("byte taken before capture window");
  early_miss_a: assert property (early |=> miss_q)
    else $error("early strobe byte not flagged");
  no_hwpoll_a: assert property ($rose(polling_q) |-> !act_work_q)
    else $error("hardware poll under workaround");
  hold_cfg_a: assert property (!idle && !$past(idle) |->
                               $stable(act_phy_q) && $stable(act_delay_q)
                               && $stable(act_staged_q))
    else $error("mode changed inside access");
  stage_lag_a: assert property (acc_v && act_staged_q |=> store_v)
    else $error("staged byte not stored next cycle");
  cs_idle_a: assert property (idle ##1 idle |-> fl_cs_n)
    else $error("chip select active while idle");
  sclk_cs_a: assert property (fl_cs_n |-> !fl_sclk)
    else $error("clock toggles without chip select");

endmodule

/* File: testbench/osp_flash_model.sv */
/*
  Behavioural octal flash: byte array for reads and writes, status
  answers with a busy bit, optional data strobe after a set lag.
  Assumes frames of opcode, three address bytes, dummy slots, data.
*/
`timescale 1ns/10ps
module osp_flash_model #(
  parameter int         DUMMY  = 8,
  parameter logic [7:0] RD_OPC = 8'h0B
) (
  input  wire logic       fl_sclk,
  input  wire logic       fl_cs_n,
  input  wire logic [7:0] fl_dq_o,
  input  wire logic       fl_dq_oe,
  input  wire logic       strobed,
  input  wire logic [7:0] lag_ns,
  output logic            fl_dqs,
  output logic      [7:0] fl_dq_i,
  output logic      [7:0] polls
);
  logic [7:0]  mem [256];
  logic [7:0]  opc = 8'h00;
  logic [23:0] adr = 24'h0;
  int          k = 0;
  int          s = 0;
  int          busy_left = 0;
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    fl_dqs = 1'b0;
    fl_dq_i = 8'hC3;
    polls = 8'h00;
  end
  // Strobe toggles only during the burst; data leads each rise by 15 ns
  task automatic burst(input logic [7:0] a);
    #(lag_ns);
    for (int i = 0; i < 4 && !fl_cs_n; i++)
    begin
      fl_dq_i = mem[a + i[7:0]];
      #15 fl_dqs = !fl_cs_n;
      #15 fl_dqs = 1'b0;
    end
    fl_dq_i = ~fl_dq_i;
  endtask
  always @(posedge fl_sclk)
  begin
    s = k;
    k = k + 1;
    if (s == 0) opc = fl_dq_o;
    else if (s < 4) adr = {adr[15:0], fl_dq_o};
    else if (fl_dq_oe && opc != RD_OPC)
    begin
      mem[adr[7:0] + 8'(s - 4)] = fl_dq_o;
      busy_left = 2;
    end
    #1;
    if (opc == osp_pkg::POLL_OPC) fl_dq_i = {7'h0, busy_left != 0};
    // Plain reads show each byte during its own slot, ahead of its rise
    else if (opc != RD_OPC || s < 3 + DUMMY) fl_dq_i = ~fl_dq_i;
    else if (!strobed) fl_dq_i = mem[adr[7:0] + 8'(s - 3 - DUMMY)];
    else if (s == 4 + DUMMY) fork burst(adr[7:0]); join_none
  end
  // Released lines show a changed value after a short hold
  always @(posedge fl_cs_n)
  begin
    if (opc == osp_pkg::POLL_OPC && k > 0)
    begin
      polls = polls + 8'h01;
      if (busy_left > 0) busy_left = busy_left - 1;
    end
    k = 0;
    #4 fl_dq_i = ~fl_dq_i;
  end
endmodule

/* File: testbench/osp_phy_read_top_tb.sv */
/*
  Self-checking bench: APB master with queued expectations, a monitor
  comparing each answer that has a queued expectation, and the flash model on the link side.
  Assumes the register map and frame timing of the block's notes.
*/
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: %h vs %h", $time, a, b); \
    end \
  end
module osp_phy_read_top_tb;
  localparam logic [7:0] RD = 8'h0B;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        strobed = 1'b1;
  logic [7:0]  lag_ns  = 8'h03;
  logic [31:0] prdata, r, d;
  logic        pready, pslverr, fl_dqs, fl_dq_oe, fl_sclk, fl_cs_n;
  logic [7:0]  fl_dq_i, fl_dq_o, polls, p0;
  logic [32:0] exp_q[$], msk_q[$], e, m;
  logic [7:0]  shadow [256];
  logic [23:0] ad;
  int          fail_count = 0;
  int          comparisons = 0;
  osp_phy_read_top #(.DUMMY(2)) DUT (.sys_clk(sys_clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_dqs(fl_dqs), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_sclk(fl_sclk), .fl_cs_n(fl_cs_n));
  osp_flash_model #(.DUMMY(2), .RD_OPC(RD)) flash (.fl_sclk(fl_sclk),
    .fl_cs_n(fl_cs_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .strobed(strobed), .lag_ns(lag_ns), .fl_dqs(fl_dqs),
    .fl_dq_i(fl_dq_i), .polls(polls));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK({pslverr, prdata} & m, e)
    end
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     input logic [32:0] ex, input logic [32:0] mk);
    int n;
    n = 0;
    if (mk != 33'h0)
    begin
      exp_q.push_back(ex & mk);
      msk_q.push_back(mk);
    end
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n == 40)
    begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd, 33'h0, 33'h1_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(a, 1'b0, 32'h0, {1'b0, ex}, 33'h1_FFFF_FFFF);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(osp_pkg::A_STAT, 1'b0, 32'h0, 33'h0, 33'h0);
      n++;
    end
    while (r[osp_pkg::ST_BUSY] !== 1'b0 && n < 200);
    if (n == 200)
    begin
      fail_count++;
      summarize();
    end
  endtask
  // Busy-time command write is refused; mode bits flip mid-access
  task automatic access(input logic [31:0] cmd, input logic [31:0] ctrl);
    wr(osp_pkg::A_CTRL, ctrl);
    wr(osp_pkg::A_CMD, cmd);
    apb(osp_pkg::A_CMD, 1'b1, cmd, 33'h1_0000_0000, 33'h1_0000_0000);
    wr(osp_pkg::A_CTRL, ctrl ^ 32'h3);
    wait_idle();
    wr(osp_pkg::A_CTRL, ctrl);
  endtask
  function automatic logic [31:0] expd(input logic [7:0] a, input int n);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < n; i++) v[8*i +: 8] = shadow[a + i[7:0]];
    return v;
  endfunction
  initial
  begin
    void'($urandom(32'habd1_4114));
    for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5A;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    `CHK({fl_cs_n, fl_sclk, fl_dq_oe}, 3'b100)
    rd(osp_pkg::A_CTRL, {29'h0, osp_pkg::CTRL_RST});
    rd(osp_pkg::A_STAT, 32'h0);
    apb(8'h1C, 1'b0, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    // Strobe lag against read delay decides capture or miss
    for (int t = 0; t < 4; t++)
    begin
      lag_ns <= (t[0] ^ t[1]) ? 8'd60 : 8'd3;
      ad = 24'($urandom());
      wr(osp_pkg::A_DELAY, t[1] ? 32'h8 : 32'h0);
      wr(osp_pkg::A_ADDR, {8'h0, ad});
      access({22'h0, 2'h3, RD}, 32'h3);
      rd(osp_pkg::A_STAT, {28'h000_0001, t[0], t[1], 2'b00});
      if (!t[0]) rd(osp_pkg::A_RX, expd(ad[7:0], 4));
      wr(osp_pkg::A_STAT, 32'h38);
    end
    strobed <= 1'b0;
    wr(osp_pkg::A_DELAY, 32'h0);
    ad = 24'($urandom()) & 24'hFF_FFFC;
    d = $urandom();
    wr(osp_pkg::A_ADDR, {8'h0, ad});
    wr(osp_pkg::A_TX, d);
    p0 = polls;
    access({20'h0_0001, 4'h1, 8'h02}, 32'h4);
    `CHK(polls, 8'(p0 + 8'd3))
    rd(osp_pkg::A_STAT, 32'h10);
    shadow[ad[7:0]] = d[7:0];
    shadow[ad[7:0] + 8'h1] = d[15:8];
    wr(osp_pkg::A_STAT, 32'h38);
    access({22'h0, 2'h1, RD}, 32'h0);
    rd(osp_pkg::A_RX, expd(ad[7:0], 2));
    // Padded command read: one leading byte, wanted bytes sit above it
    wr(osp_pkg::A_ADDR, {8'h0, ad - 24'h1});
    access({22'h0, 2'h2, RD}, 32'h0);
    rd(osp_pkg::A_RX, expd(ad[7:0] - 8'h1, 3));
    wr(osp_pkg::A_DELAY, 32'h8);
    p0 = polls;
    access({20'h0_0001, 4'h0, 8'h02}, 32'h7);
    `CHK(polls, p0)
    rd(osp_pkg::A_STAT, 32'h34);
    wr(osp_pkg::A_STAT, 32'h38);
    for (int i = 0; i < 3; i++)
    begin
      access({24'h0, osp_pkg::POLL_OPC}, 32'h0);
      rd(osp_pkg::A_RX, {31'h0, i < 2});
    end
    summarize();
  end
endmodule
